// ==== include/lpc_pkg.sv ====
/*
 * constants for the link pin configuration bank: register offsets,
 * field positions, reset values and pin mode encodings.
 * assumes a 32-bit ahb-lite register bus, one word per register.
 */
package lpc_pkg;
  // printed offsets are not word multiples: these are indices
  localparam logic [7:0] IDX_PIN0_SETUP = 8'h1D;
  localparam logic [7:0] IDX_PINS1_2_SETUP = 8'h1E;
  localparam logic [7:0] IDX_PIN3_SETUP = 8'h1F;
  localparam logic [7:0] IDX_PORT_CTRL = 8'h30;
  localparam logic [7:0] IDX_PIN_STATUS = 8'h31;
  // field positions within a nibble
  localparam int POS_FUNC_EN = 0;
  localparam int POS_DIR = 1;
  localparam int POS_REMOTE = 2;
  localparam int POS_LEVEL = 3;
  localparam int POS_HI_NIBBLE = 4;
  // reset values of the writable nibbles
  localparam logic [3:0] RST_PIN_NIBBLE = 4'h0;
  localparam logic RST_PORT_SEL = 1'b0;
  // arbitrary neutral revision value
  localparam logic [3:0] REVISION_CODE = 4'h5;
  // {direction, function_enable}
  localparam logic [1:0] MODE_FUNCTIONAL = 2'h0;
  localparam logic [1:0] MODE_GP_OUT = 2'h1;
  localparam logic [1:0] MODE_TRISTATE = 2'h2;
  localparam logic [1:0] MODE_GP_IN = 2'h3;
  localparam int NUM_PINS = 4;
endpackage : lpc_pkg

// ==== rtl/lpc_pin_bank.sv ====
/*
 * link pin configuration bank: three setup registers steer four pins,
 * or the second port's four pins when the port select is set.
 * assumes functional signals, link values and pin inputs come from
 * outside; link values and pin inputs are synchronised here.
 */
// Implementation choice: the AHB-Lite register port.
// ****************************************************************
// Overview of operation
// RULE_01 - mode 00 functional output, 10 tri-state
// RULE_02 - mode 01 gp output, 11 gp input
// RULE_03 - local level driven only in gp output
// RULE_04 - remote bit forces output with link value
// RULE_05 - remote bit clear ignores link value
// RULE_06 - port select moves control to second port
// RULE_07 - low nibble: enable bit0, direction bit1
// RULE_08 - high nibble: enable bit4, direction bit5
// RULE_09 - reserved and revision bits ignore writes
// ****************************************************************
`timescale 1ns/100ps
module lpc_pin_bank #(
  parameter int NPINS = lpc_pkg::NUM_PINS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NPINS-1:0] func_out,
  input wire logic [NPINS-1:0] link_value,
  input wire logic [NPINS-1:0] pin_in,
  input wire logic [NPINS-1:0] second_pin_in,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe,
  output logic [NPINS-1:0] second_pin_out,
  output logic [NPINS-1:0] second_pin_oe,
  output logic [NPINS-1:0] pin_sampled,
  output logic secondary_port_select
);
  // ****************************************************************
  // register bus
  // ****************************************************************
  logic wr_pend;
  logic [7:0] wr_idx;
  logic [3:0] pin_nib [NPINS];
  logic [NPINS-1:0] link_s1, link_s2, in_s1, in_s2, sin_s1, sin_s2;

  function automatic logic [7:0] idx_of(input logic [31:0] a);
    idx_of = a[9:2];
  endfunction : idx_of

  function automatic logic [1:0] mode_of(input logic [3:0] n);
    // pair is {direction, function_enable}
    mode_of = {n[lpc_pkg::POS_DIR], n[lpc_pkg::POS_FUNC_EN]}; // RULE_07
  endfunction : mode_of

  wire addr_ok = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
    end else begin
      wr_pend <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_idx <= idx_of(haddr);
      end
    end
  end

  // every transfer completes in zero wait states with OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // register contents as they stand after this edge; the read decode
  // uses them too, so a read right behind a write sees the new value
  // instead of the contents from before the write's data phase
  logic [3:0] next_nib [NPINS];
  logic next_port_select;
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      next_nib[i] = pin_nib[i];
    end
    next_port_select = secondary_port_select;
    if (wr_pend) begin
      // only the low nibble of pin0 and pin3 setup is writable
      case (wr_idx)
        lpc_pkg::IDX_PIN0_SETUP: next_nib[0] = hwdata[3:0]; // RULE_09
        lpc_pkg::IDX_PINS1_2_SETUP: begin
          next_nib[1] = hwdata[3:0]; // RULE_07
          next_nib[2] = hwdata[7:4]; // RULE_08
        end
        lpc_pkg::IDX_PIN3_SETUP: next_nib[3] = hwdata[3:0]; // RULE_09
        lpc_pkg::IDX_PORT_CTRL: next_port_select = hwdata[0];
        default: ;
      endcase
    end
  end

  // a write lands at the end of its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NPINS; i++) begin
        pin_nib[i] <= lpc_pkg::RST_PIN_NIBBLE;
      end
      secondary_port_select <= lpc_pkg::RST_PORT_SEL;
    end else if (wr_pend) begin
      for (int i = 0; i < NPINS; i++) begin
        pin_nib[i] <= next_nib[i];
      end
      secondary_port_select <= next_port_select;
    end
  end

  // read data decoded in the address phase, registered for data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      case (idx_of(haddr))
        lpc_pkg::IDX_PIN0_SETUP:
          hrdata <= {24'h00_0000, lpc_pkg::REVISION_CODE, next_nib[0]};
        lpc_pkg::IDX_PINS1_2_SETUP:
          hrdata <= {24'h00_0000, next_nib[2], next_nib[1]};
        lpc_pkg::IDX_PIN3_SETUP:
          hrdata <= {28'h000_0000, next_nib[3]}; // RULE_09
        lpc_pkg::IDX_PORT_CTRL:
          hrdata <= {31'h0000_0000, next_port_select};
        // status is read-only, so no write can be in flight for it
        lpc_pkg::IDX_PIN_STATUS:
          hrdata <= 32'(pin_sampled);
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_s1 <= '0;
      link_s2 <= '0;
      in_s1 <= '0;
      in_s2 <= '0;
      sin_s1 <= '0;
      sin_s2 <= '0;
    end else begin
      link_s1 <= link_value;
      link_s2 <= link_s1;
      in_s1 <= pin_in;
      in_s2 <= in_s1;
      sin_s1 <= second_pin_in;
      sin_s2 <= sin_s1;
    end
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  logic [NPINS-1:0] next_out, next_oe;
  always_comb begin
    next_out = '0;
    next_oe = '0;
    for (int i = 0; i < NPINS; i++) begin
      if (pin_nib[i][lpc_pkg::POS_REMOTE]) begin
        next_oe[i] = 1'b1; // RULE_04
        next_out[i] = link_s2[i]; // RULE_04
      end else begin
        // link value not consulted here
        case (mode_of(pin_nib[i])) // RULE_05
          lpc_pkg::MODE_FUNCTIONAL: begin
            next_oe[i] = 1'b1; // RULE_01
            next_out[i] = func_out[i]; // RULE_01
          end
          lpc_pkg::MODE_TRISTATE: next_oe[i] = 1'b0; // RULE_01
          lpc_pkg::MODE_GP_OUT: begin
            next_oe[i] = 1'b1; // RULE_02
            next_out[i] = pin_nib[i][lpc_pkg::POS_LEVEL]; // RULE_03
          end
          lpc_pkg::MODE_GP_IN: next_oe[i] = 1'b0; // RULE_02
          default: next_oe[i] = 1'b0;
        endcase
      end
    end
  end

  // the unselected port is parked undriven
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out <= '0;
      pin_oe <= '0;
      second_pin_out <= '0;
      second_pin_oe <= '0;
      pin_sampled <= '0;
    end else if (secondary_port_select) begin
      pin_out <= '0;
      pin_oe <= '0;
      second_pin_out <= next_out; // RULE_06
      second_pin_oe <= next_oe; // RULE_06
      pin_sampled <= sin_s2; // RULE_06
    end else begin
      pin_out <= next_out;
      pin_oe <= next_oe;
      second_pin_out <= '0;
      second_pin_oe <= '0;
      pin_sampled <= in_s2;
    end
  end
endmodule : lpc_pin_bank

// ==== test/lpc_far_end.sv ====
/* far-end serializer model: puts remote pin values on the link.
 * assumes the bench sets the values just after an hclk edge. */
`timescale 1ns/100ps
module lpc_far_end (
  input wire logic hclk,
  input wire logic [3:0] cmd,
  output logic [3:0] link_value
);
  // registered launch, as the link delivers one update a cycle
  always_ff @(posedge hclk) begin
    link_value <= cmd;
  end
endmodule : lpc_far_end

// ==== test/lpc_chk.sv ====
/* port checker of lpc_pin_bank.
 * assumes it is bound to the top module and hready is hreadyout. */
`timescale 1ns/100ps
module lpc_chk #(parameter int NPINS = 4) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [NPINS-1:0] pin_oe,
  input wire logic [NPINS-1:0] second_pin_oe,
  input wire logic secondary_port_select
);
  logic rd;
  assign rd = hsel && hready && htrans[1] && !hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or okay");
  property p_rev; rd && haddr == 32'h74 |=>
    hrdata[7:4] == lpc_pkg::REVISION_CODE; endproperty
  a_rev: assert property (p_rev) else $error("revision bad");
  property p_res; rd && haddr == 32'h7C |=> hrdata[7:4] == 4'h0; endproperty
  a_res: assert property (p_res) else $error("reserved bad");
  property p_top; rd |=> hrdata[31:8] == 24'h0; endproperty
  a_top: assert property (p_top) else $error("upper bits set");
  property p_unm; rd && haddr == 32'h100 |=> hrdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_sel; rd && haddr == 32'hC0 |=>
    hrdata[0] == secondary_port_select; endproperty
  a_sel: assert property (p_sel) else $error("select readback");
  property p_pri; secondary_port_select[*2] |-> pin_oe == '0; endproperty
  a_pri: assert property (p_pri) else $error("primary driven");
  property p_sec; !secondary_port_select[*2] |-> second_pin_oe == '0;
  endproperty
  a_sec: assert property (p_sec) else $error("second driven");
  c_rev: cover property (rd && haddr == 32'h74);
  c_sel: cover property (secondary_port_select);
  c_oe: cover property (pin_oe != '0);
endmodule : lpc_chk

// ==== test/tb.sv ====
/* self-checking bench of lpc_pin_bank over ahb-lite.
 * assumes zero-wait answers and pin outputs settled in 6 cycles. */
`timescale 1ns/100ps
module tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sps;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [3:0] func_out, link_value, cmd, sec_in, po, oe, so, soe, smp;
  logic [3:0] pin_lvl;
  int bad_count, n_checks;
  lpc_pin_bank i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .func_out(func_out),
    .link_value(link_value), .pin_in(pin_lvl), .second_pin_in(sec_in),
    .pin_out(po), .pin_oe(oe), .second_pin_out(so), .second_pin_oe(soe),
    .pin_sampled(smp), .secondary_port_select(sps));
  lpc_far_end i_far (.hclk(hclk), .cmd(cmd), .link_value(link_value));
  initial begin
    hclk = 1'h0;
    forever #12.5 hclk = ~hclk;
  end

  // byte address of a register index: one aligned word per register
  function automatic logic [31:0] adr(input logic [7:0] idx);
    adr = {22'h00_0000, idx, 2'h0};
  endfunction : adr

  task chk(input string s, input logic [31:0] e, input logic [31:0] v);
    n_checks++;
    if (v !== e) begin
      bad_count++;
      $display("mismatch %s exp %h seen %h", s, e, v);
    end
  endtask : chk

  task results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // one edge, then more until hready is seen high; bounded wait
  task rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'h1) begin
      @(posedge hclk);
      n++;
      if (n > 20) begin
        bad_count++;
        results;
      end
    end
  endtask : rdy

  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask : bus

  task cfg(input logic [3:0] n);
    bus(1'h1, adr(lpc_pkg::IDX_PIN0_SETUP), {24'h00_0000, 4'hF, n});
    bus(1'h1, adr(lpc_pkg::IDX_PINS1_2_SETUP), {24'h00_0000, n, n});
    bus(1'h1, adr(lpc_pkg::IDX_PIN3_SETUP), {24'h00_0000, 4'hF, n});
    repeat (6) @(posedge hclk);
  endtask : cfg

  task t_reset;
    bus(1'h0, adr(lpc_pkg::IDX_PIN0_SETUP), 32'h0000_0000);
    chk("rst0", {lpc_pkg::REVISION_CODE, 4'h0}, q);
    bus(1'h0, adr(lpc_pkg::IDX_PINS1_2_SETUP), 32'h0000_0000);
    chk("rst12", 32'h0000_0000, q);
    bus(1'h0, adr(lpc_pkg::IDX_PIN3_SETUP), 32'h0000_0000);
    chk("rst3", 32'h0000_0000, q);
    chk("rstoe", 8'hFA, {oe, po});
    $display("reset test done");
  endtask : t_reset

  task t_modes;
    logic [3:0] n;
    logic [3:0] eo;
    for (int k = 0; k < 5; k++) begin
      n = (k == 4) ? 4'h1 : {2'h2, k[1:0]};
      eo = (k < 2 || k == 4) ? 4'hF : 4'h0;
      cfg(n);
      chk("oe", eo, oe);
      if (k == 0) begin
        chk("func", 4'hA, po);
      end
      if (k % 3 == 1) begin
        chk("lvl", (k == 1) ? 4'hF : 4'h0, po);
      end
    end
    bus(1'h0, adr(lpc_pkg::IDX_PIN0_SETUP), 32'h0000_0000);
    chk("ro0", {lpc_pkg::REVISION_CODE, 4'h1}, q);
    bus(1'h0, adr(lpc_pkg::IDX_PIN3_SETUP), 32'h0000_0000);
    chk("ro3", 32'h0000_0001, q);
    $display("mode test done");
  endtask : t_modes

  task t_remote;
    cmd <= 4'h5;
    cfg(4'h7);
    chk("rem", 8'hF5, {oe, po});
    cmd <= 4'hA;
    repeat (6) @(posedge hclk);
    chk("rem2", 8'hFA, {oe, po});
    cfg(4'h1);
    chk("local", 8'hF0, {oe, po});
    $display("remote test done");
  endtask : t_remote

  task t_port;
    cfg(4'h9);
    sec_in <= 4'h6;
    bus(1'h1, adr(lpc_pkg::IDX_PORT_CTRL), 32'h0000_0001);
    repeat (6) @(posedge hclk);
    chk("sec", 12'h0FF, {oe, soe, so});
    chk("sel", 1'h1, sps);
    chk("smp", 4'h6, smp);
    bus(1'h0, adr(lpc_pkg::IDX_PORT_CTRL), 32'h0000_0000);
    chk("selrd", 32'h0000_0001, q);
    bus(1'h0, adr(lpc_pkg::IDX_PIN_STATUS), 32'h0000_0000);
    chk("smprd", 32'h0000_0006, q);
    bus(1'h0, adr(8'h40), 32'h0000_0000);
    chk("unmap", 32'h0000_0000, q);
    bus(1'h1, adr(lpc_pkg::IDX_PORT_CTRL), 32'h0000_0000);
    repeat (6) @(posedge hclk);
    chk("pri", 16'hFF00, {oe, po, soe, so});
    chk("sel0", 1'h0, sps);
    chk("smp0", 4'h3, smp);
    $display("port test done");
  endtask : t_port

  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    hwrite = 1'h0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    func_out = 4'hA;
    cmd = 4'h0;
    sec_in = 4'h0;
    pin_lvl = 4'h3;
    bad_count = 0;
    n_checks = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_reset;
    t_modes;
    t_remote;
    t_port;
    results;
  end
endmodule : tb
bind lpc_pin_bank lpc_chk #(.NPINS(NPINS)) i_chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .pin_oe(pin_oe), .second_pin_oe(second_pin_oe),
  .secondary_port_select(secondary_port_select));
